// ---- design/t1_cfg_pkg.sv ----
package t1_cfg_pkg;

  // ----------------------------------------
  // Frame geometry and rates
  // ----------------------------------------
  localparam int NUM_CH         = 24;
  localparam int FRAME_BITS     = 193;
  localparam int SF_FRAMES      = 24;
  localparam int SIG_EVERY      = 6;
  localparam int RATE56_KBPS    = 56;
  localparam int RATE64_KBPS    = 64;
  localparam int DS0_MGMT_KBPS  = 8;
  localparam int FULL_RATE_KBPS = 1536;
  localparam int CLK_KHZ        = 200000;
  localparam int T1_KHZ         = 1544;
  localparam int INT_DIV        = CLK_KHZ / T1_KHZ;
  localparam int FIFO_DEPTH     = 32;
  localparam int SYNC_N         = 5;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] MAP0_OFS = 5'h04;
  localparam logic [4:0] MAP1_OFS = 5'h08;
  localparam logic [4:0] MAP2_OFS = 5'h0C;
  localparam logic [4:0] STAT_OFS = 5'h10;
  localparam int MAP_PER_WORD = 8;
  localparam int MAP_FIELD_W  = 4;
  localparam int CTRL_W       = 12;
  localparam int ST_CNT_LSB   = 0;
  localparam int ST_AGG_LSB   = 5;
  localparam int ST_MRATE_LSB = 16;
  localparam int ST_SRC_LSB   = 24;
  localparam int ST_OVR_BIT   = 30;
  localparam int ST_REJ_BIT   = 31;

  typedef enum logic [2:0] {
    SRC_NET, SRC_INT, SRC_DTE, SRC_THRU, SRC_TERM
  } timing_src_e;

  typedef enum logic [1:0] {DEST_IDLE, DEST_DATA, DEST_TERM} chan_dest_e;

  typedef struct packed {
    logic       voice;
    chan_dest_e dest;
  } chan_cfg_s;

  typedef struct packed {
    logic        net_esf;
    logic        mgmt_fdl;
    logic        mgmt_en;
    logic [4:0]  mgmt_ch;
    logic        rate64;
    timing_src_e src;
  } ctrl_s;

  localparam logic [11:0] CTRL_RST = 12'h808;
  localparam logic [2:0]  MAP_RST  = 3'h1;

endpackage

// ---- design/t1_channel_map_timing_select.sv ----
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps

module t1_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule // t1_bit_fifo

module t1_channel_map_timing_select
  import t1_cfg_pkg::*;
#(
  parameter int DIV   = INT_DIV,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output      logic [31:0] avs_readdata_out,
  output      logic        avs_waitrequest_out,
  // Line and equipment clocks, network receive stream
  input  wire logic        net_rx_clk_in,
  input  wire logic        net_rx_data_in,
  input  wire logic        net_rx_frame_in,
  input  wire logic        term_rx_clk_in,
  input  wire logic        dte_tx_clk_in,
  // Transmit timing ticks
  output      logic        net_tx_tick_out,
  output      logic        term_tx_tick_out,
  // Data port, terminal port, management link
  output      logic        dp_rx_data_out,
  output      logic        dp_rx_valid_out,
  output      logic        term_tx_data_out,
  output      logic        term_sig_bit_out,
  output      logic        term_tx_valid_out,
  output      logic        mgmt_rx_bit_out,
  output      logic        mgmt_rx_valid_out,
  output      logic        dp_overrun_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] s1_reg;
  logic [SYNC_N-1:0] s2_reg;
  logic [SYNC_N-1:0] s3_reg;
  logic net_edge, term_edge, dte_edge, d_bit, frm;

  assign raw = {dte_tx_clk_in, term_rx_clk_in, net_rx_frame_in,
                net_rx_data_in, net_rx_clk_in};
  assign net_edge  = s2_reg[0] & ~s3_reg[0];
  assign d_bit     = s2_reg[1];
  assign frm       = s2_reg[2];
  assign term_edge = s2_reg[3] & ~s3_reg[3];
  assign dte_edge  = s2_reg[4] & ~s3_reg[4];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ----------------------------------------
  // Internal oscillator
  // ----------------------------------------
  logic [7:0] div_reg;
  logic       int_tick;
  assign int_tick = div_reg == 8'(DIV - 1);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || int_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Bus decode and configuration check
  // ----------------------------------------
  ctrl_s            ctrl_reg;
  ctrl_s            cand_ctrl;
  chan_cfg_s        map_reg [NUM_CH];
  logic [NUM_CH-1:0] cand_term, cand_bad, cur_term, cur_dp, cur_voice;
  logic [31:0]      cand_term32;
  logic req, take, wr_take, ctrl_wr, map_wr, stat_wr, upd, rej_set;
  logic cfg_ok, thru_bad, mgmt_bad, fdl_bad, src_bad;
  logic [1:0]       map_idx;
  logic [31:0]      rd_mux, status;

  assign req     = avs_read_in | avs_write_in;
  assign take    = req & ~avs_waitrequest_out;
  assign wr_take = avs_write_in & take;
  assign ctrl_wr = wr_take & (avs_address_in == CTRL_OFS);
  assign stat_wr = wr_take & (avs_address_in == STAT_OFS);
  assign map_wr  = wr_take & ((avs_address_in == MAP0_OFS) |
                   (avs_address_in == MAP1_OFS) |
                   (avs_address_in == MAP2_OFS));
  assign map_idx = avs_address_in[3:2] - 2'h1;
  assign cand_ctrl = ctrl_wr ? ctrl_s'(avs_writedata_in[CTRL_W-1:0])
                             : ctrl_reg;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    chan_cfg_s cand_ch;
    localparam logic [1:0] WI = 2'(i / MAP_PER_WORD);
    localparam int         FB = (i % MAP_PER_WORD) * MAP_FIELD_W;
    assign cand_ch = (map_wr && map_idx == WI)
                   ? chan_cfg_s'(avs_writedata_in[FB +: 3]) : map_reg[i];
    assign cand_term[i] = cand_ch.dest == DEST_TERM;
    assign cand_bad[i]  = cand_ch.dest == chan_dest_e'(2'h3);
    assign cur_term[i]  = map_reg[i].dest == DEST_TERM;
    assign cur_dp[i]    = map_reg[i].dest == DEST_DATA;
    assign cur_voice[i] = map_reg[i].voice;

    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        map_reg[i] <= chan_cfg_s'(MAP_RST);
      end else if (map_wr && cfg_ok) begin
        map_reg[i] <= cand_ch;
      end
    end
  end

  assign cand_term32 = {8'h00, cand_term};
  assign src_bad  = cand_ctrl.src > SRC_TERM;
  assign thru_bad = (cand_ctrl.src == SRC_THRU) & ~&cand_term;
  assign mgmt_bad = cand_ctrl.mgmt_en & ~cand_ctrl.mgmt_fdl &
                    ((cand_ctrl.mgmt_ch >= 5'(NUM_CH)) |
                     cand_term32[cand_ctrl.mgmt_ch]);
  assign fdl_bad  = cand_ctrl.mgmt_en & cand_ctrl.mgmt_fdl &
                    ~cand_ctrl.net_esf;
  assign cfg_ok   = ~(src_bad | thru_bad | mgmt_bad | fdl_bad | |cand_bad);
  assign upd      = ctrl_wr & cfg_ok;
  assign rej_set  = (ctrl_wr | map_wr) & ~cfg_ok;

  // ----------------------------------------
  // Status view
  // ----------------------------------------
  logic [4:0]  dp_count;
  logic [10:0] agg_kbps;
  logic [6:0]  port_rate, mgmt_rate;
  logic        rej_reg, ovr_reg, fifo_rdy, fifo_vld, fifo_dat, dp_take;
  timing_src_e src_act_reg;

  assign dp_count  = 5'($countones(cur_dp));
  assign port_rate = ctrl_reg.rate64 ? 7'(RATE64_KBPS)
                                     : 7'(RATE56_KBPS);
  // Widen before the product, a 7-bit product would wrap at 128, well below 1536
  assign agg_kbps  = 11'(dp_count) * 11'(port_rate);
  assign mgmt_rate = (~ctrl_reg.mgmt_en | ctrl_reg.mgmt_fdl) ? 7'h00
                   : cur_dp[ctrl_reg.mgmt_ch] ? 7'(DS0_MGMT_KBPS)
                   : port_rate;
  assign status = {rej_reg, ovr_reg, 3'h0, src_act_reg, 1'b0,
                   mgmt_rate, agg_kbps, dp_count};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_in)
      CTRL_OFS: rd_mux = {20'h0_0000, ctrl_reg};
      MAP0_OFS, MAP1_OFS, MAP2_OFS: begin
        for (int k = 0; k < MAP_PER_WORD; k++) begin
          rd_mux[k*MAP_FIELD_W +: 3] = map_reg[int'(map_idx)*MAP_PER_WORD+k];
        end
      end
      STAT_OFS: rd_mux = status;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      ctrl_reg            <= ctrl_s'(CTRL_RST);
      rej_reg             <= 1'b0;
      ovr_reg             <= 1'b0;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (req && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
      if (upd) begin
        ctrl_reg <= cand_ctrl;
      end
      // Set beats a same-cycle clear
      rej_reg <= rej_set |
                 (rej_reg & ~(stat_wr & avs_writedata_in[ST_REJ_BIT]));
      ovr_reg <= (dp_take & ~fifo_rdy) |
                 (ovr_reg & ~(stat_wr & avs_writedata_in[ST_OVR_BIT]));
    end
  end

  // ----------------------------------------
  // Transmit timing selection
  // ----------------------------------------
  logic       src_tick, net_tick, term_tick, tx_wrap;
  logic [7:0] tx_cnt_reg;

  assign src_tick = (src_act_reg == SRC_INT)  ? int_tick :
                    (src_act_reg == SRC_DTE)  ? dte_edge :
                    (src_act_reg == SRC_TERM) ? term_edge :
                    net_edge;
  assign net_tick  = (src_act_reg == SRC_THRU) ? term_edge : src_tick;
  assign term_tick = (src_act_reg == SRC_THRU) ? net_edge : src_tick;
  assign tx_wrap   = net_tick & (tx_cnt_reg == 8'(FRAME_BITS - 1));

  // Switch only at a frame edge so the outgoing alignment survives
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      src_act_reg      <= SRC_NET;
      tx_cnt_reg       <= 8'h00;
      net_tx_tick_out  <= 1'b0;
      term_tx_tick_out <= 1'b0;
    end else begin
      net_tx_tick_out  <= net_tick;
      term_tx_tick_out <= term_tick;
      if (tx_wrap) begin
        tx_cnt_reg  <= 8'h00;
        src_act_reg <= ctrl_reg.src;
      end else if (net_tick) begin
        tx_cnt_reg <= tx_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Receive channel demultiplexer
  // ----------------------------------------
  logic [7:0] bit_cnt_reg, cur_bit, cm1;
  logic [4:0] frame_reg, ch;
  logic [2:0] bpos;
  logic       fbit, lsb, sigf, robbed, mgmt_here, mg_take, tm_take;
  chan_cfg_s  ch_cfg;

  assign cur_bit   = frm ? 8'h00 : bit_cnt_reg;
  assign cm1       = cur_bit - 8'h01;
  assign ch        = cm1[7:3];
  assign bpos      = cm1[2:0];
  assign fbit      = cur_bit == 8'h00;
  assign ch_cfg    = fbit ? chan_cfg_s'(3'h0) : map_reg[ch];
  assign lsb       = bpos == 3'h7;
  assign sigf      = (frame_reg % 5'(SIG_EVERY)) == 5'(SIG_EVERY - 1);
  assign robbed    = lsb & sigf;
  assign mgmt_here = ctrl_reg.mgmt_en & ~ctrl_reg.mgmt_fdl & ~fbit &
                     (ch == ctrl_reg.mgmt_ch);
  assign dp_take   = net_edge & (ch_cfg.dest == DEST_DATA) &
                     ~(lsb & (~ctrl_reg.rate64 | mgmt_here));
  assign mg_take   = net_edge & ((ctrl_reg.mgmt_en & ctrl_reg.mgmt_fdl &
                     ctrl_reg.net_esf & fbit & ~frame_reg[0]) |
                     (mgmt_here & ((ch_cfg.dest == DEST_DATA) ? lsb :
                     ~(lsb & ~ctrl_reg.rate64))));
  assign tm_take   = net_edge & (ch_cfg.dest == DEST_TERM);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bit_cnt_reg       <= 8'h00;
      frame_reg         <= 5'h00;
      term_tx_data_out  <= 1'b1;
      term_sig_bit_out  <= 1'b0;
      term_tx_valid_out <= 1'b0;
      mgmt_rx_bit_out   <= 1'b0;
      mgmt_rx_valid_out <= 1'b0;
    end else begin
      term_tx_valid_out <= tm_take;
      mgmt_rx_valid_out <= mg_take;
      if (net_edge) begin
        bit_cnt_reg <= (cur_bit == 8'(FRAME_BITS - 1)) ? 8'h00
                                                       : cur_bit + 8'h01;
      end
      if (net_edge && fbit) begin
        frame_reg <= (frame_reg == 5'(SF_FRAMES - 1)) ? 5'h00
                                                      : frame_reg + 5'h01;
      end
      if (tm_take) begin
        term_tx_data_out <= (ch_cfg.voice | ~robbed) ? d_bit : 1'b1;
        term_sig_bit_out <= robbed & ch_cfg.voice;
      end
      if (mg_take) begin
        mgmt_rx_bit_out <= d_bit;
      end
    end
  end

  // ----------------------------------------
  // Data port buffer, drained on the network tick
  // ----------------------------------------
  t1_bit_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (dp_take),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (d_bit),
    .out_valid_out (fifo_vld),
    .out_ready_in  (net_tick),
    .out_data_out  (fifo_dat)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dp_rx_data_out  <= 1'b1;
      dp_rx_valid_out <= 1'b0;
      dp_overrun_out  <= 1'b0;
    end else begin
      dp_rx_valid_out <= net_tick & fifo_vld;
      dp_overrun_out  <= ovr_reg;
      if (net_tick) begin
        dp_rx_data_out <= fifo_vld ? fifo_dat : 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_loop_ticks: assert property ((src_act_reg == SRC_NET) && net_edge
    |=> net_tx_tick_out && term_tx_tick_out) else $error("loop tick");
  a_int_ticks: assert property ((src_act_reg == SRC_INT) && int_tick
    |=> net_tx_tick_out && term_tx_tick_out) else $error("int tick");
  a_dte_ticks: assert property ((src_act_reg == SRC_DTE) && !dte_edge
    |=> !net_tx_tick_out && !term_tx_tick_out) else $error("dte tick");
  a_thru_split: assert property ((src_act_reg == SRC_THRU) && term_edge
    && !net_edge |=> net_tx_tick_out && !term_tx_tick_out)
    else $error("through split");
  a_thru_legal: assert property ((ctrl_reg.src == SRC_THRU) |-> &cur_term)
    else $error("through with non-terminal channel");
  a_term_ticks: assert property ((src_act_reg == SRC_TERM) && term_edge
    |=> net_tx_tick_out && term_tx_tick_out) else $error("term tick");
  a_mgmt_not_term: assert property (ctrl_reg.mgmt_en && !ctrl_reg.mgmt_fdl
    |-> !cur_term[ctrl_reg.mgmt_ch]) else $error("mgmt on term");
  a_clear_chan: assert property (tm_take && !ch_cfg.voice && robbed
    |=> term_tx_data_out && !term_sig_bit_out) else $error("clear");
  a_full_rate: assert property ((dp_count == 5'(NUM_CH)) && ctrl_reg.rate64
    |-> agg_kbps == 11'(FULL_RATE_KBPS)) else $error("aggregate");
  a_fdl_esf: assert property (ctrl_reg.mgmt_en && ctrl_reg.mgmt_fdl
    |-> ctrl_reg.net_esf) else $error("fdl without esf");
  a_src_at_frame: assert property ($changed(src_act_reg)
    |-> $past(tx_wrap)) else $error("source change mid-frame");
  a_bus_answer: assert property (req && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");

  c_thru_run: cover property (src_act_reg == SRC_THRU ##1 net_tx_tick_out);
  c_reject:   cover property (rej_set);
  c_overrun:  cover property (dp_take && !fifo_rdy);
  c_mgmt_bit: cover property (mg_take && lsb);
endmodule // t1_channel_map_timing_select

// ---- tb/t1_line_model.sv ----
`timescale 1ns/100ps
module t1_line_model (
  // Clock enables and payload
  input  wire logic       run_in,
  input  wire logic       term_run_in,
  input  wire logic       dte_run_in,
  input  wire logic [7:0] pattern_in,
  // Line side
  output      logic       net_clk_out,
  output      logic       net_data_out,
  output      logic       net_frame_out,
  output      logic       term_clk_out,
  output      logic       dte_clk_out,
  output      int         frames_out
);
  int bit_idx;

  initial begin
    net_clk_out = 0;
    term_clk_out = 0;
    dte_clk_out = 0;
    net_data_out = 1;
    net_frame_out = 1;
    bit_idx = 0;
    frames_out = 0;
  end

  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  // Disabled clocks freeze, so a dead source really delivers no edges
  always begin
    #24;
    if (run_in) net_clk_out = ~net_clk_out;
  end
  always begin
    #25;
    if (term_run_in) term_clk_out = ~term_clk_out;
  end
  always begin
    #30;
    if (dte_run_in) dte_clk_out = ~dte_clk_out;
  end

  // ----------------------------------------
  // Framed bit stream
  // ----------------------------------------
  // Launch on falling edge, half a period clear of the sampling edge
  always @(negedge net_clk_out) begin
    bit_idx = (bit_idx == 192) ? 0 : bit_idx + 1;
    if (bit_idx == 0) frames_out++;
    net_frame_out = (bit_idx == 0);
    net_data_out = (bit_idx == 0) ? frames_out[0]
                 : pattern_in[7 - ((bit_idx - 1) % 8)];
  end
endmodule // t1_line_model

// ---- tb/test_t1_channel_map_timing_select.sv ----
`timescale 1ns/100ps
module test_t1_channel_map_timing_select import t1_cfg_pkg::*;;
  localparam int TB_DIV = 20;
  logic        clk_in, sys_rst_in, avs_read_in, avs_write_in;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
  logic        avs_waitrequest_out, net_rx_clk_in, net_rx_data_in;
  logic        net_rx_frame_in, term_rx_clk_in, dte_tx_clk_in;
  logic        net_tx_tick_out, term_tx_tick_out, dp_rx_data_out;
  logic        dp_rx_valid_out, term_tx_data_out, term_sig_bit_out;
  logic        term_tx_valid_out, mgmt_rx_bit_out, mgmt_rx_valid_out;
  logic        dp_overrun_out, dte_run;
  int          frames, bad_count, n_checks, nt, tt, sc, oc, dv, mc, dz;

  t1_channel_map_timing_select #(.DIV(TB_DIV), .DEPTH(FIFO_DEPTH)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .net_rx_clk_in(net_rx_clk_in), .net_rx_data_in(net_rx_data_in),
    .net_rx_frame_in(net_rx_frame_in), .term_rx_clk_in(term_rx_clk_in),
    .dte_tx_clk_in(dte_tx_clk_in), .net_tx_tick_out(net_tx_tick_out),
    .term_tx_tick_out(term_tx_tick_out), .dp_rx_data_out(dp_rx_data_out),
    .dp_rx_valid_out(dp_rx_valid_out), .term_tx_data_out(term_tx_data_out),
    .term_sig_bit_out(term_sig_bit_out),
    .term_tx_valid_out(term_tx_valid_out),
    .mgmt_rx_bit_out(mgmt_rx_bit_out),
    .mgmt_rx_valid_out(mgmt_rx_valid_out), .dp_overrun_out(dp_overrun_out));

  t1_line_model line (
    .run_in(1'b1), .term_run_in(1'b1), .dte_run_in(dte_run),
    .pattern_in(8'h00), .net_clk_out(net_rx_clk_in),
    .net_data_out(net_rx_data_in), .net_frame_out(net_rx_frame_in),
    .term_clk_out(term_rx_clk_in), .dte_clk_out(dte_tx_clk_in),
    .frames_out(frames));

  // ----------------------------------------
  // Clock and event counters
  // ----------------------------------------
  always #2.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (net_tx_tick_out === 1'b1) nt++;
    if (term_tx_tick_out === 1'b1) tt++;
    if (dp_rx_valid_out === 1'b1) dv++;
    if (term_tx_valid_out === 1'b1 && term_sig_bit_out === 1'b1) sc++;
    if (term_tx_valid_out === 1'b1 && term_tx_data_out === 1'b1) oc++;
    if (mgmt_rx_valid_out === 1'b1) mc++;
    // Payload pattern is all zeros, so any other delivered bit is wrong
    if (dp_rx_valid_out === 1'b1 && dp_rx_data_out !== 1'b0) dz++;
    if (mgmt_rx_valid_out === 1'b1 && mgmt_rx_bit_out !== 1'b0) dz++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
      bad_count++;
    end
  endtask

  // Edge counts race the window ends, so one count of slack
  task automatic near(input string nm, input int e, int g);
    n_checks++;
    if (g < e - 1 || g > e + 1) begin
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !w;
    avs_write_in <= w;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 50) bad_count++;
    rdata = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [4:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic wait_frames(input int n);
    int f0, k;
    f0 = frames;
    k = 0;
    while (frames < f0 + n && k < 20000 * n) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 20000 * n) bad_count++;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(CTRL_OFS);
    chk("ctrl", 32'h808, rdata);
    for (int i = 0; i < 3; i++) begin
      rd(MAP0_OFS + 5'(4 * i));
      chk("map", 32'h11111111, rdata);
    end
    rd(STAT_OFS);
    chk("status", 32'h0000C018, rdata & 32'h3FFFFFFF);
    rd(5'h14);
    chk("unmapped", 32'h0, rdata);
  endtask

  task automatic t_rate();
    wr(CTRL_OFS, 32'h800);
    rd(STAT_OFS);
    chk("agg56", 32'h540, 32'(rdata[15:5]));
    wr(CTRL_OFS, 32'h808);
  endtask

  task automatic rej(input logic [31:0] c);
    wr(CTRL_OFS, c);
    rd(STAT_OFS);
    chk("reject", 32'h1, 32'(rdata[31]));
    rd(CTRL_OFS);
    chk("ctrl kept", 32'h808, rdata);
    wr(STAT_OFS, 32'h80000000);
  endtask

  task automatic t_mgmt();
    int m0;
    wr(MAP0_OFS, 32'h11111112);
    rej(32'h00000A08);
    wr(CTRL_OFS, 32'hA18);
    rd(STAT_OFS);
    chk("mgmt ds0", 32'h08, 32'(rdata[22:16]));
    chk("accepted", 32'h0, 32'(rdata[31]));
    wait_frames(1);
    m0 = mc;
    wait_frames(2);
    chk("mgmt bits", 32'h2, 32'(mc - m0));
    wr(MAP0_OFS, 32'h11111012);
    wr(CTRL_OFS, 32'hA28);
    rd(STAT_OFS);
    chk("mgmt idle", 32'h40, 32'(rdata[22:16]));
    chk("dp count", 32'h16, 32'(rdata[4:0]));
    chk("agg", 32'h580, 32'(rdata[15:5]));
    wr(CTRL_OFS, 32'h808);
  endtask

  task automatic t_robbed(input logic [3:0] f, input int es, int eo);
    int s0, o0;
    wr(MAP0_OFS, {28'h1111111, f});
    wait_frames(1);
    s0 = sc;
    o0 = oc;
    wait_frames(6);
    chk("sig bits", 32'(es), 32'(sc - s0));
    chk("forced ones", 32'(eo), 32'(oc - o0));
  endtask

  task automatic t_src(input logic [2:0] s, input int en, int et);
    int n0, t0, k;
    wr(CTRL_OFS, {20'h0, 9'h101, s});
    k = 0;
    rd(STAT_OFS);
    while (rdata[26:24] !== s && k < 3000) begin
      rd(STAT_OFS);
      k++;
    end
    chk("source", 32'(s), 32'(rdata[26:24]));
    n0 = nt;
    t0 = tt;
    repeat (480) @(posedge clk_in);
    near("net ticks", en, nt - n0);
    near("term ticks", et, tt - t0);
  endtask

  task automatic t_overrun();
    int d0;
    dte_run <= 1'b0;
    repeat (2000) @(posedge clk_in);
    rd(STAT_OFS);
    chk("overrun", 32'h1, 32'(rdata[30]));
    chk("overrun pin", 32'h1, 32'(dp_overrun_out));
    dte_run <= 1'b1;
    wr(STAT_OFS, 32'h40000000);
    d0 = dv;
    repeat (480) @(posedge clk_in);
    chk("draining", 32'h1, 32'(dv > d0 + 20));
    chk("payload ones", 32'h0, 32'(dz));
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {clk_in, avs_read_in, avs_write_in} = 3'b000;
    {nt, tt, sc, oc, dv, mc, dz, bad_count, n_checks} = '0;
    sys_rst_in = 1'b1;
    dte_run = 1'b1;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_rate();
    rej(32'h0000080B);
    rej(32'h0000080D);
    rej(32'h00000608);
    t_mgmt();
    t_robbed(4'h6, 1, 0);
    t_robbed(4'h2, 0, 1);
    t_src(3'h0, 50, 50);
    t_src(3'h1, 24, 24);
    t_src(3'h2, 40, 40);
    t_src(3'h4, 48, 48);
    for (int i = 0; i < 3; i++) wr(MAP0_OFS + 5'(4 * i), 32'h22222222);
    t_src(3'h3, 48, 50);
    // Leave through timing first, or the map restore is refused
    t_src(3'h2, 40, 40);
    for (int i = 0; i < 3; i++) wr(MAP0_OFS + 5'(4 * i), 32'h11111111);
    t_overrun();
    give_verdict();
  end

  initial begin
    #450000;
    bad_count++;
    give_verdict();
  end
endmodule // test_t1_channel_map_timing_select
